/* File: rtl/dgc_global_control.sv */
// Contract
// - codes 01, 10 give orders 0,2,3,1 and 2,0,1,3; 11 is round robin
// - code 00 gives fixed order 0,1,2,3
// - bits 7 to 3 read as zero; software writes zero there
// - own address errors set the address error flag, bit 2
// - address error flag high blocks and suspends every channel
// - writing 1 to address error flag ignored; clear by 0 after reading 1
// - nmi input sets nmi flag, bit 1, whether operating or suspended
// - nmi flag high prohibits and suspends every channel
// - writing 1 to nmi flag ignored; clear by 0 after reading 1
// - channel enabled only with master enable and its channel enable set
// - clearing master enable mid transfer suspends all channels
// - transfer end, channel enable low, nmi or address error block channel
`timescale 1ns/1ps
`default_nettype none

module dgc_global_control
  import dgc_pkg::*;
(
  // clock and reset
  input  wire  logic                      clk_sys,
  input  wire  logic                      reset_n,
  // wishbone slave
  input  wire  logic                      wb_cyc_i,
  input  wire  logic                      wb_stb_i,
  input  wire  logic                      wb_we_i,
  input  wire  logic [dgc_pkg::DGC_ADDR_W-1:0] wb_adr_i,
  input  wire  logic [3:0]                wb_sel_i,
  input  wire  logic [dgc_pkg::DGC_DATA_W-1:0] wb_dat_i,
  output var   logic [dgc_pkg::DGC_DATA_W-1:0] wb_dat_o,
  output var   logic                      wb_ack_o,
  output var   logic                      wb_err_o,
  // channel side
  input  wire  dgc_pkg::dgc_evt_t         evtIn,
  input  wire  logic                      nmiPin,
  output var   dgc_pkg::dgc_ctl_t         ctlOut
);
  import dgc_pkg::*;

  logic        nmiSync1_q;
  logic        nmiSync2_q;
  logic        nmiSync3_q;
  logic        masterEnable_q;
  logic        nmiFlag_q;
  logic        addrErrFlag_q;
  logic [1:0]  prioSel_q;
  logic [3:0]  chanEnable_q;
  logic        nmiSeen_q;
  logic        addrErrSeen_q;
  logic [3:0]  rrOrder_q [DGC_CHANNELS];
  logic [3:0]  grant_d;
  logic [3:0]  allowed_d;
  logic [3:0]  eligible;
  dgc_prio_t   prioMode;
  logic        nmiEdge;
  logic        reqValid;
  logic        opSel;
  logic        chSel;
  logic        wrLow;
  logic        wrHigh;
  logic [15:0] opRead;
  logic [1:0]  rrHit;

  assign reqValid = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign opSel    = reqValid && (wb_adr_i == DGC_OPCTL_ADDR);
  assign chSel    = reqValid && (wb_adr_i == DGC_CHCTL_ADDR);
  assign wrLow    = wb_we_i && wb_sel_i[0];
  assign wrHigh   = wb_we_i && wb_sel_i[1];
  assign nmiEdge  = nmiSync2_q && !nmiSync3_q;

  // nmi pin synchroniser and edge
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      nmiSync1_q <= 1'b0;
      nmiSync2_q <= 1'b0;
      nmiSync3_q <= 1'b0;
    end else begin
      nmiSync1_q <= nmiPin;
      nmiSync2_q <= nmiSync1_q;
      nmiSync3_q <= nmiSync2_q;
    end
  end

  // enable, priority and channel enables
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      masterEnable_q <= DGC_OPCTL_RESET[DGC_ENABLE_BIT];
      prioSel_q      <= DGC_PRIO_RESET;
      chanEnable_q   <= DGC_CHEN_RESET;
    end else begin
      if (opSel && wrLow) begin
        masterEnable_q <= wb_dat_i[DGC_ENABLE_BIT];
      end
      if (opSel && wrHigh) begin
        prioSel_q <= wb_dat_i[DGC_PRIO_HI_BIT:DGC_PRIO_LO_BIT];
      end
      if (chSel && wrLow) begin
        chanEnable_q <= wb_dat_i[3:0];
      end
    end
  end

  // read-one arming for the sticky clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      nmiSeen_q     <= 1'b0;
      addrErrSeen_q <= 1'b0;
    end else if (opSel) begin
      if (!wb_we_i) begin
        nmiSeen_q     <= nmiFlag_q;
        addrErrSeen_q <= addrErrFlag_q;
      end else if (wrLow) begin
        nmiSeen_q     <= 1'b0;
        addrErrSeen_q <= 1'b0;
      end
    end
  end

  // sticky flags, set wins over clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      nmiFlag_q     <= DGC_OPCTL_RESET[DGC_NMI_BIT];
      addrErrFlag_q <= DGC_OPCTL_RESET[DGC_ADDRERR_BIT];
    end else begin
      if (nmiEdge) begin
        nmiFlag_q <= 1'b1;
      end else if (opSel && wrLow && nmiSeen_q && !wb_dat_i[DGC_NMI_BIT]) begin
        nmiFlag_q <= 1'b0;
      end
      if (evtIn.addrErrEvent) begin
        addrErrFlag_q <= 1'b1;
      end else if (opSel && wrLow && addrErrSeen_q && !wb_dat_i[DGC_ADDRERR_BIT]) begin
        addrErrFlag_q <= 1'b0;
      end
    end
  end

  // per channel enable gating
  always_comb begin
    for (int i = 0; i < DGC_CHANNELS; i++) begin
      allowed_d[i] = masterEnable_q && chanEnable_q[i] && !evtIn.transferEnd[i]
                     && !nmiFlag_q && !addrErrFlag_q;
    end
    eligible = allowed_d & evtIn.request;
  end

  always_comb begin
    unique case (prioSel_q)
      2'h0:    prioMode = DGC_PRIO_FIXED;
      2'h1:    prioMode = DGC_PRIO_ALT_A;
      2'h2:    prioMode = DGC_PRIO_ALT_B;
      default: prioMode = DGC_PRIO_ROUND;
    endcase
  end

  // arbitration
  always_comb begin
    grant_d = 4'h0;
    rrHit   = 2'h0;
    unique case (prioMode)
      DGC_PRIO_FIXED: begin
        if (eligible[0])      grant_d = 4'h1;
        else if (eligible[1]) grant_d = 4'h2;
        else if (eligible[2]) grant_d = 4'h4;
        else if (eligible[3]) grant_d = 4'h8;
      end
      DGC_PRIO_ALT_A: begin
        if (eligible[0])      grant_d = 4'h1;
        else if (eligible[2]) grant_d = 4'h4;
        else if (eligible[3]) grant_d = 4'h8;
        else if (eligible[1]) grant_d = 4'h2;
      end
      DGC_PRIO_ALT_B: begin
        if (eligible[2])      grant_d = 4'h4;
        else if (eligible[0]) grant_d = 4'h1;
        else if (eligible[1]) grant_d = 4'h2;
        else if (eligible[3]) grant_d = 4'h8;
      end
      DGC_PRIO_ROUND: begin
        for (int k = DGC_CHANNELS - 1; k >= 0; k--) begin
          if ((eligible & rrOrder_q[k]) != 4'h0) begin
            grant_d = rrOrder_q[k];
            rrHit   = 2'(k);
          end
        end
      end
    endcase
  end

  // round robin order, slot 0 highest
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rrOrder_q[0] <= 4'h1;
      rrOrder_q[1] <= 4'h2;
      rrOrder_q[2] <= 4'h4;
      rrOrder_q[3] <= 4'h8;
    end else if (prioMode == DGC_PRIO_ROUND && grant_d != 4'h0) begin
      for (int k = 0; k < DGC_CHANNELS; k++) begin
        if (k >= int'(rrHit) && k < DGC_CHANNELS - 1) begin
          rrOrder_q[k] <= rrOrder_q[k + 1];
        end
      end
      rrOrder_q[DGC_CHANNELS - 1] <= grant_d;
    end
  end

  // control outputs
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctlOut <= '0;
    end else begin
      ctlOut.grant          <= grant_d;
      ctlOut.channelAllowed <= allowed_d;
      ctlOut.suspendAll     <= evtIn.transferActive
                               && (!masterEnable_q || nmiFlag_q || addrErrFlag_q);
    end
  end

  always_comb begin
    opRead                                   = 16'h0000;
    opRead[DGC_PRIO_HI_BIT:DGC_PRIO_LO_BIT]  = prioSel_q;
    opRead[DGC_ADDRERR_BIT]                  = addrErrFlag_q;
    opRead[DGC_NMI_BIT]                      = nmiFlag_q;
    opRead[DGC_ENABLE_BIT]                   = masterEnable_q;
  end

  // wishbone answer, one cycle after request
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= opSel || chSel;
      wb_err_o <= reqValid && !opSel && !chSel;
      if (opSel && !wb_we_i) begin
        wb_dat_o <= {16'h0000, opRead};
      end else if (chSel && !wb_we_i) begin
        wb_dat_o <= {20'h00000, evtIn.transferEnd, 4'h0, chanEnable_q};
      end else begin
        wb_dat_o <= '0;
      end
    end
  end

endmodule : dgc_global_control

`default_nettype wire

/* File: rtl/dgc_pkg.sv */
package dgc_pkg;

  localparam int          DGC_CHANNELS     = 4;
  localparam int          DGC_ADDR_W       = 4;
  localparam int          DGC_DATA_W       = 32;

  // register byte addresses
  localparam logic [3:0]  DGC_OPCTL_ADDR   = 4'h0;
  localparam logic [3:0]  DGC_CHCTL_ADDR   = 4'h4;

  // operation control fields
  localparam int          DGC_ENABLE_BIT   = 0;
  localparam int          DGC_NMI_BIT      = 1;
  localparam int          DGC_ADDRERR_BIT  = 2;
  localparam int          DGC_PRIO_LO_BIT  = 8;
  localparam int          DGC_PRIO_HI_BIT  = 9;
  localparam logic [15:0] DGC_OPCTL_RESET  = 16'h0000;
  localparam logic [1:0]  DGC_PRIO_RESET   = 2'h0;

  // channel control: enable bits in [3:0], transfer end flags read in [11:8]
  localparam int          DGC_TEND_LSB     = 8;
  localparam logic [3:0]  DGC_CHEN_RESET   = 4'h0;

  typedef enum logic [3:0] {
    DGC_PRIO_FIXED  = 4'b0001,
    DGC_PRIO_ALT_A  = 4'b0010,
    DGC_PRIO_ALT_B  = 4'b0100,
    DGC_PRIO_ROUND  = 4'b1000
  } dgc_prio_t;

  typedef struct packed {
    logic [3:0] request;
    logic [3:0] transferEnd;
    logic       nmiEvent;
    logic       addrErrEvent;
    logic       transferActive;
  } dgc_evt_t;

  typedef struct packed {
    logic [3:0] grant;
    logic [3:0] channelAllowed;
    logic       suspendAll;
  } dgc_ctl_t;

endpackage : dgc_pkg

/* File: tb/dgc_global_control_props.sv */
`timescale 1ns/1ps
`default_nettype none
module dgc_global_control_props
  import dgc_pkg::*;
(
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              reset_n,
  // bus
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [3:0]        wb_adr_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              wb_err_o,
  // channels
  input wire dgc_pkg::dgc_evt_t evtIn,
  input wire logic              nmiPin,
  input wire dgc_pkg::dgc_ctl_t ctlOut
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
    else $error("no answer");
  chk_reserved_zero: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == DGC_OPCTL_ADDR
    |-> wb_dat_o[7:3] == 5'h0 && wb_dat_o[31:10] == 22'h0) else $error("reserved bits set");
  chk_grant_onehot: assert property ($onehot0(ctlOut.grant)) else $error("grant not one-hot");
  chk_grant_request: assert property ((ctlOut.grant & ~$past(evtIn.request)) == 4'h0)
    else $error("grant without request");
  chk_end_blocks: assert property ((ctlOut.channelAllowed & $past(evtIn.transferEnd)) == 4'h0)
    else $error("ended channel allowed");
  chk_suspend_cause: assert property (ctlOut.suspendAll |-> $past(evtIn.transferActive))
    else $error("suspend while idle");
  chk_nmi_halt: assert property ($rose(nmiPin) ##1 evtIn.transferActive [*7]
    |-> ctlOut.suspendAll && ctlOut.channelAllowed == 4'h0) else $error("nmi did not halt");
  chk_addr_halt: assert property (evtIn.addrErrEvent |-> ##3 ctlOut.channelAllowed == 4'h0)
    else $error("address error did not halt");
endmodule : dgc_global_control_props
`default_nettype wire

/* File: tb/tb_dgc_global_control.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checkCount++; if ((g) !== (e)) begin fails++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_dgc_global_control;
  import dgc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, nmiPin = 1'b0, ack, err, lastErr;
  logic [3:0]  adr = 4'h0, sel = 4'h0, te;
  logic [31:0] wdat = 32'h0, dat, rdat, seed = 32'h48;
  dgc_evt_t    evt = '0;
  dgc_ctl_t    ctl;
  int          fails = 0, checkCount = 0, cycN = 0;
  int          rr[$] = '{0, 1, 2, 3};
  dgc_global_control dut (.clk_sys, .reset_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack), .wb_err_o(err), .evtIn(evt), .nmiPin,
    .ctlOut(ctl));
  initial forever #50 clk_sys = ~clk_sys;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic stopTest();
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stopTest
  always @(posedge clk_sys) begin
    cycN++;
    if (cycN == 20000) begin
      fails++;
      stopTest();
    end
  end
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    wdat <= {16'h0, d};
    do @(posedge clk_sys); while (!(ack || err));
    rdat = dat;
    lastErr = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 16'h0);
    `CHK("read", e, rdat)
  endtask : rd
  task automatic look(input logic [3:0] e, input logic s);
    @(negedge clk_sys);
    `CHK("allowed", e, ctl.channelAllowed)
    `CHK("suspend", s, ctl.suspendAll)
    @(posedge clk_sys);
  endtask : look
  task automatic arb(input logic [1:0] p, input logic [3:0] r);
    int         o[$];
    int         g;
    logic [3:0] e;
    e = 4'h0;
    case (p)
      2'h0: o = '{0, 1, 2, 3};
      2'h1: o = '{0, 2, 3, 1};
      2'h2: o = '{2, 0, 1, 3};
      default: o = rr;
    endcase
    foreach (o[i]) if (e == 4'h0 && r[o[i]]) e[o[i]] = 1'b1;
    evt.request <= r;
    @(posedge clk_sys);
    evt.request <= 4'h0;
    @(negedge clk_sys);
    `CHK("grant", e, ctl.grant)
    for (int i = 0; i < 4; i++) begin
      if (p == 2'h3 && e[rr[i]]) begin
        g = rr[i];
        rr.delete(i);
        rr.push_back(g);
        break;
      end
    end
    @(posedge clk_sys);
  endtask : arb
  initial begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    evt.transferActive <= 1'b1;
    @(posedge clk_sys);
    rd(DGC_OPCTL_ADDR, 32'h0);
    bus(1'b1, DGC_OPCTL_ADDR, 16'h0307);
    rd(DGC_OPCTL_ADDR, 32'h301);
    bus(1'b1, 4'h8, 16'h1);
    `CHK("err", 1'b1, lastErr)
    $display("test registers done");
    bus(1'b1, DGC_CHCTL_ADDR, 16'hf);
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, DGC_OPCTL_ADDR, {6'h0, 2'(p), 8'h1});
      repeat (12) arb(2'(p), 4'(xs()));
    end
    $display("test priority done");
    te = 4'(xs());
    evt.transferEnd <= te;
    @(posedge clk_sys);
    look(4'hf & ~te, 1'b0);
    rd(DGC_CHCTL_ADDR, {20'h0, te, 8'h0f});
    evt.transferEnd <= 4'h0;
    bus(1'b1, DGC_OPCTL_ADDR, 16'h0);
    look(4'h0, 1'b1);
    for (int f = 1; f < 3; f++) begin
      bus(1'b1, DGC_OPCTL_ADDR, 16'h1);
      if (f == 1) nmiPin <= 1'b1;
      else evt.addrErrEvent <= 1'b1;
      @(posedge clk_sys);
      evt.addrErrEvent <= 1'b0;
      repeat (8) @(posedge clk_sys);
      nmiPin <= 1'b0;
      look(4'h0, 1'b1);
      bus(1'b1, DGC_OPCTL_ADDR, 16'h1);
      rd(DGC_OPCTL_ADDR, 32'h1 | (32'h1 << f));
      bus(1'b1, DGC_OPCTL_ADDR, 16'h1);
      rd(DGC_OPCTL_ADDR, 32'h1);
    end
    $display("test flags done");
    stopTest();
  end
endmodule : tb_dgc_global_control
bind dgc_global_control dgc_global_control_props props (.clk_sys, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .evtIn, .nmiPin, .ctlOut);
`default_nettype wire
